// File: pwm16_pkg.sv
`default_nettype none
package pwm16_pkg;

  typedef logic [15:0] word_t;
  typedef logic [3:0]  addr_t;

  // Register indices on the plain register port.
  localparam addr_t ADDR_CTRL    = 4'h0;
  localparam addr_t ADDR_PIN_DIR = 4'h1;
  localparam addr_t ADDR_COUNT   = 4'h2;
  localparam addr_t ADDR_CMP_A   = 4'h3;
  localparam addr_t ADDR_CMP_B   = 4'h4;
  localparam addr_t ADDR_CAP_TOP = 4'h5;
  localparam addr_t ADDR_FLAGS   = 4'h6;
  localparam addr_t ADDR_STATUS  = 4'h7;

  // Control register fields.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_COMA_LSB = 4;
  localparam int CTRL_COMB_LSB = 6;
  localparam int CTRL_CSEL_LSB = 8;
  localparam logic [10:0] CTRL_RESET = 11'h000;

  // Flag register bits.
  localparam int FLAG_OVF  = 0;
  localparam int FLAG_CMPA = 1;
  localparam int FLAG_CMPB = 2;
  localparam int FLAG_CAPT = 3;

  // Status register bits.
  localparam int STAT_UP    = 0;
  localparam int STAT_WAVEA = 1;
  localparam int STAT_WAVEB = 2;

  // Waveform mode codes.
  localparam logic [3:0] MODE_PC8    = 4'h1;
  localparam logic [3:0] MODE_PC9    = 4'h2;
  localparam logic [3:0] MODE_PC10   = 4'h3;
  localparam logic [3:0] MODE_PFC_IC = 4'h8;
  localparam logic [3:0] MODE_PFC_CA = 4'h9;
  localparam logic [3:0] MODE_PC_IC  = 4'hA;
  localparam logic [3:0] MODE_PC_CA  = 4'hB;

  // Fixed top values.
  localparam word_t TOP_8BIT  = 16'h00FF;
  localparam word_t TOP_9BIT  = 16'h01FF;
  localparam word_t TOP_10BIT = 16'h03FF;
  localparam word_t TOP_MAX   = 16'hFFFF;
  localparam word_t BOTTOM    = 16'h0000;
  localparam word_t WORD_ONE  = 16'h0001;

  // Output action codes.
  localparam logic [1:0] COM_OFF    = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_NONINV = 2'h2;
  localparam logic [1:0] COM_INV    = 2'h3;

  // Prescaler select codes and their divide masks.
  localparam logic [2:0] CSEL_DIV1    = 3'h1;
  localparam logic [2:0] CSEL_DIV8    = 3'h2;
  localparam logic [2:0] CSEL_DIV64   = 3'h3;
  localparam logic [2:0] CSEL_DIV256  = 3'h4;
  localparam logic [2:0] CSEL_DIV1024 = 3'h5;
  localparam logic [9:0] PRE_MASK_1    = 10'h000;
  localparam logic [9:0] PRE_MASK_8    = 10'h007;
  localparam logic [9:0] PRE_MASK_64   = 10'h03F;
  localparam logic [9:0] PRE_MASK_256  = 10'h0FF;
  localparam logic [9:0] PRE_MASK_1024 = 10'h3FF;

endpackage
`default_nettype wire

// File: pwm16_prescaler.sv
`timescale 1ns/100ps
`default_nettype none
module pwm16_prescaler (
  input  wire logic       clk_sys_in,
  input  wire logic       nrst_in,
  input  wire logic [2:0] sel_in,
  output logic            tick_out
);
  import pwm16_pkg::*;

  logic [9:0] pre_q;
  logic [9:0] mask_w;
  logic       run_w;

  assign run_w  = (sel_in >= CSEL_DIV1) && (sel_in <= CSEL_DIV1024);
  assign mask_w = (sel_in == CSEL_DIV8)    ? PRE_MASK_8 :
                  (sel_in == CSEL_DIV64)   ? PRE_MASK_64 :
                  (sel_in == CSEL_DIV256)  ? PRE_MASK_256 :
                  (sel_in == CSEL_DIV1024) ? PRE_MASK_1024 : PRE_MASK_1;
  // The divided enable sets the period factor N of the output waveform.
  assign tick_out = run_w && ((pre_q & mask_w) == mask_w);

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pre_q <= 10'h000;
    end else begin
      pre_q <= pre_q + 10'h001;
    end
  end

  a_div_eight: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (sel_in == CSEL_DIV8 && tick_out) |=>
      (!tick_out || sel_in != CSEL_DIV8) [*7]
      ##1 (tick_out || sel_in != CSEL_DIV8))
    else $error("divide by eight enable spacing wrong");

endmodule
`default_nettype wire

// File: pwm16_channel.sv
`timescale 1ns/100ps
`default_nettype none
module pwm16_channel (
  input  wire logic             clk_sys_in,
  input  wire logic             nrst_in,
  input  wire logic             wr_in,
  input  wire pwm16_pkg::word_t wdata_in,
  input  wire pwm16_pkg::word_t mask_in,
  input  wire logic             load_in,
  input  wire pwm16_pkg::word_t cnt_in,
  input  wire pwm16_pkg::word_t top_in,
  input  wire logic             tick_in,
  input  wire logic             up_in,
  input  wire logic             pwm_en_in,
  input  wire logic [1:0]       com_in,
  input  wire logic             toggle_ok_in,
  output logic                  match_out,
  output pwm16_pkg::word_t      buf_out,
  output pwm16_pkg::word_t      act_out,
  output logic                  wave_out
);
  import pwm16_pkg::*;

  word_t buf_q;
  word_t act_q;
  logic  wave_q;
  logic  wave_d;
  logic  lvl_w;

  // A top below the active value never matches.
  assign match_out = tick_in && (cnt_in == act_q);
  assign buf_out   = buf_q;
  assign act_out   = act_q;
  assign wave_out  = wave_q;

  // Level for non-inverted output; extremes pin the level.
  assign lvl_w = (act_q == BOTTOM) ? 1'b0 :
                 (act_q == top_in) ? 1'b1 : !up_in;

  always_comb begin
    wave_d = wave_q;
    if (match_out && pwm_en_in) begin
      case (com_in)
        COM_NONINV: wave_d = lvl_w;
        COM_INV:    wave_d = !lvl_w;
        COM_TOGGLE: wave_d = toggle_ok_in ? !wave_q : wave_q;
        default:    wave_d = wave_q;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      buf_q  <= BOTTOM;
      act_q  <= BOTTOM;
      wave_q <= 1'b0;
    end else begin
      if (wr_in) begin
        buf_q <= wdata_in & mask_in;
      end
      if (load_in) begin
        act_q <= buf_q;
      end
      wave_q <= wave_d;
    end
  end

  a_update_load: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in)
    load_in |=> act_q == $past(buf_q))
    else $error("active compare did not load from buffer");

  a_mask_write: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in)
    wr_in |=> (buf_q & ~$past(mask_in)) == BOTTOM)
    else $error("compare write not masked to resolution");

  a_wave_dir: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in)
    (match_out && pwm_en_in && com_in == COM_NONINV && act_q != BOTTOM
     && act_q != top_in) |=> (wave_q == !$past(up_in)))
    else $error("non-inverted output moved the wrong way");

  a_toggle_match: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in)
    (match_out && pwm_en_in && com_in == COM_TOGGLE && toggle_ok_in)
    |=> wave_q != $past(wave_q))
    else $error("toggle output did not toggle");

endmodule
`default_nettype wire

// File: dual_slope_pwm_timer16.sv
// Functional notes
// - Phase correct top: fixed, capture or compare A
// - At top reverse; top held one tick
// - Count equal compare sets compare flag
// - Phase correct sets overflow at bottom
// - Phase correct loads compares at top, flags
// - Fixed top masks compare write bits
// - Top below compare gives no match
// - Code two non-inverted, three inverted
// - Pin driven only when direction is output
// - Clear on up match, set on down
// - Bottom compare low, top compare high
// - Compare A top mode toggles at half duty
// - Phase correct period runs top to top
// - Frequency correct: capture or compare A top
// - Frequency correct loads at bottom, sets overflow
// - Frequency correct sets top flag at top
// - Frequency correct compare A top toggles
// - Output frequency is clock over 2*N*top
// - Capture top written without buffering
// - Compare A writes go through buffer
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module dual_slope_pwm_timer16 (
  input  wire logic             clk_sys_in,
  input  wire logic             nrst_in,
  input  wire pwm16_pkg::addr_t addr_in,
  input  wire pwm16_pkg::word_t wdata_in,
  input  wire logic             wr_in,
  input  wire logic             rd_in,
  output pwm16_pkg::word_t      rdata_out,
  output logic                  pin_a_out,
  output logic                  pin_a_oe_n_out,
  output logic                  pin_b_out,
  output logic                  pin_b_oe_n_out
);
  import pwm16_pkg::*;

  typedef enum logic {DIR_DOWN, DIR_UP} dir_t;

  // Register state.
  logic [10:0] ctrl_q;
  logic [1:0]  pin_dir_q;
  word_t       cnt_q;
  word_t       cnt_d;
  word_t       cap_top_q;
  logic [3:0]  flags_q;
  logic [3:0]  flags_d;
  dir_t        dir_q;
  dir_t        dir_d;
  word_t       rdata_q;

  // Decoded controls.
  logic [3:0] waveform_mode_select;
  logic [1:0] output_action_a;
  logic [1:0] output_action_b;
  logic [2:0] clk_sel_w;
  logic       fixed_w;
  logic       pc_w;
  logic       pfc_w;
  logic       dual_w;
  logic       up_w;
  word_t      top_w;
  word_t      mask_w;

  // Timing events.
  logic  tick_w;
  logic  at_top_w;
  logic  at_bottom_w;
  logic  load_w;
  logic  match_a_w;
  logic  match_b_w;
  logic  toggle_ok_a_w;
  logic  capt_top_w;
  logic  cmpa_top_w;
  word_t cmp_a_buf_w;
  word_t cmp_a_act_w;
  word_t cmp_b_buf_w;
  word_t cmp_b_act_w;
  logic  wave_a_w;
  logic  wave_b_w;

  // Bus decode.
  logic       wr_ctrl_w;
  logic       wr_dir_w;
  logic       wr_cnt_w;
  logic       wr_cmpa_w;
  logic       wr_cmpb_w;
  logic       wr_cap_w;
  logic       wr_flags_w;
  logic [3:0] flag_clr_w;
  logic [3:0] flag_set_w;
  word_t      rd_mux_w;

  assign wr_ctrl_w  = wr_in && (addr_in == ADDR_CTRL);
  assign wr_dir_w   = wr_in && (addr_in == ADDR_PIN_DIR);
  assign wr_cnt_w   = wr_in && (addr_in == ADDR_COUNT);
  assign wr_cmpa_w  = wr_in && (addr_in == ADDR_CMP_A);
  assign wr_cmpb_w  = wr_in && (addr_in == ADDR_CMP_B);
  assign wr_cap_w   = wr_in && (addr_in == ADDR_CAP_TOP);
  assign wr_flags_w = wr_in && (addr_in == ADDR_FLAGS);

  assign waveform_mode_select = ctrl_q[CTRL_MODE_LSB +: 4];
  assign output_action_a      = ctrl_q[CTRL_COMA_LSB +: 2];
  assign output_action_b      = ctrl_q[CTRL_COMB_LSB +: 2];
  assign clk_sel_w            = ctrl_q[CTRL_CSEL_LSB +: 3];

  assign fixed_w = (waveform_mode_select == MODE_PC8) ||
                   (waveform_mode_select == MODE_PC9) ||
                   (waveform_mode_select == MODE_PC10);
  assign pc_w    = fixed_w || (waveform_mode_select == MODE_PC_IC) ||
                   (waveform_mode_select == MODE_PC_CA);
  assign pfc_w   = (waveform_mode_select == MODE_PFC_IC) ||
                   (waveform_mode_select == MODE_PFC_CA);
  assign dual_w  = pc_w || pfc_w;
  assign up_w    = (dir_q == DIR_UP);

  assign capt_top_w = (waveform_mode_select == MODE_PC_IC) ||
                      (waveform_mode_select == MODE_PFC_IC);
  assign cmpa_top_w = (waveform_mode_select == MODE_PC_CA) ||
                      (waveform_mode_select == MODE_PFC_CA);
  assign toggle_ok_a_w = cmpa_top_w;

  // Top selection; capture top is used live, never buffered.
  assign top_w = (waveform_mode_select == MODE_PC8)  ? TOP_8BIT :
                 (waveform_mode_select == MODE_PC9)  ? TOP_9BIT :
                 (waveform_mode_select == MODE_PC10) ? TOP_10BIT :
                 capt_top_w ? cap_top_q :
                 cmpa_top_w ? cmp_a_act_w : TOP_MAX;
  assign mask_w = fixed_w ? top_w : TOP_MAX;

  assign at_top_w    = tick_w && dual_w && (cnt_q == top_w);
  assign at_bottom_w = tick_w && dual_w && (cnt_q == BOTTOM);

  // Compare update point: top in phase correct, bottom in frequency
  // correct, every cycle in the unbuffered modes outside this block.
  // Loading at top makes a phase correct period span top to top, so a
  // top change gives an unsymmetrical period; users who retune the
  // period on the fly should pick frequency correct mode.
  assign load_w = pc_w  ? at_top_w :
                  pfc_w ? at_bottom_w :
                  1'b1;

  assign flag_set_w[FLAG_OVF]  = at_bottom_w;
  assign flag_set_w[FLAG_CMPA] = match_a_w;
  assign flag_set_w[FLAG_CMPB] = match_b_w;
  assign flag_set_w[FLAG_CAPT] = at_top_w && capt_top_w;
  assign flag_clr_w = wr_flags_w ? wdata_in[3:0] : 4'h0;
  // A flag raised in the cycle of its clear stays set.
  assign flags_d = (flags_q & ~flag_clr_w) | flag_set_w;

  // Waveform pins: the direction bit gates the driver.
  assign pin_a_out      = pin_dir_q[0] && wave_a_w;
  assign pin_a_oe_n_out = !(pin_dir_q[0] && dual_w &&
                            (output_action_a != COM_OFF));
  assign pin_b_out      = pin_dir_q[1] && wave_b_w;
  assign pin_b_oe_n_out = !(pin_dir_q[1] && dual_w &&
                            (output_action_b != COM_OFF));

  assign rd_mux_w =
    (addr_in == ADDR_CTRL)    ? {5'h00, ctrl_q} :
    (addr_in == ADDR_PIN_DIR) ? {14'h0000, pin_dir_q} :
    (addr_in == ADDR_COUNT)   ? cnt_q :
    (addr_in == ADDR_CMP_A)   ? cmp_a_buf_w :
    (addr_in == ADDR_CMP_B)   ? cmp_b_buf_w :
    (addr_in == ADDR_CAP_TOP) ? cap_top_q :
    (addr_in == ADDR_FLAGS)   ? {12'h000, flags_q} :
    (addr_in == ADDR_STATUS)  ? {13'h0000, wave_b_w, wave_a_w, up_w} :
    BOTTOM;
  assign rdata_out = rdata_q;

  // Dual-slope count: the top value is seen for one tick, then the
  // count turns. A top written below the count runs on to wrap.
  always_comb begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    if (wr_cnt_w) begin
      cnt_d = wdata_in;
    end else if (tick_w) begin
      if (!dual_w) begin
        cnt_d = cnt_q + WORD_ONE;
      end else begin
        case (dir_q)
          DIR_UP: begin
            if (cnt_q == top_w) begin
              dir_d = DIR_DOWN;
              cnt_d = cnt_q - WORD_ONE;
            end else begin
              cnt_d = cnt_q + WORD_ONE;
            end
          end
          DIR_DOWN: begin
            if (cnt_q == BOTTOM) begin
              dir_d = DIR_UP;
              cnt_d = cnt_q + WORD_ONE;
            end else begin
              cnt_d = cnt_q - WORD_ONE;
            end
          end
          default: begin
            dir_d = DIR_UP;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_q    <= CTRL_RESET;
      pin_dir_q <= 2'h0;
      cap_top_q <= BOTTOM;
      flags_q   <= 4'h0;
      rdata_q   <= BOTTOM;
    end else begin
      if (wr_ctrl_w) begin
        ctrl_q <= wdata_in[10:0];
      end
      if (wr_dir_w) begin
        pin_dir_q <= wdata_in[1:0];
      end
      if (wr_cap_w) begin
        cap_top_q <= wdata_in;
      end
      flags_q <= flags_d;
      rdata_q <= rd_in ? rd_mux_w : BOTTOM;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_q <= BOTTOM;
      dir_q <= DIR_UP;
    end else begin
      cnt_q <= cnt_d;
      dir_q <= dir_d;
    end
  end

  pwm16_prescaler u_prescaler (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .sel_in     (clk_sel_w),
    .tick_out   (tick_w)
  );

  pwm16_channel u_channel_a (
    .clk_sys_in   (clk_sys_in),
    .nrst_in      (nrst_in),
    .wr_in        (wr_cmpa_w),
    .wdata_in     (wdata_in),
    .mask_in      (mask_w),
    .load_in      (load_w),
    .cnt_in       (cnt_q),
    .top_in       (top_w),
    .tick_in      (tick_w),
    .up_in        (up_w),
    .pwm_en_in    (dual_w),
    .com_in       (output_action_a),
    .toggle_ok_in (toggle_ok_a_w),
    .match_out    (match_a_w),
    .buf_out      (cmp_a_buf_w),
    .act_out      (cmp_a_act_w),
    .wave_out     (wave_a_w)
  );

  pwm16_channel u_channel_b (
    .clk_sys_in   (clk_sys_in),
    .nrst_in      (nrst_in),
    .wr_in        (wr_cmpb_w),
    .wdata_in     (wdata_in),
    .mask_in      (mask_w),
    .load_in      (load_w),
    .cnt_in       (cnt_q),
    .top_in       (top_w),
    .tick_in      (tick_w),
    .up_in        (up_w),
    .pwm_en_in    (dual_w),
    .com_in       (output_action_b),
    .toggle_ok_in (1'b0),
    .match_out    (match_b_w),
    .buf_out      (cmp_b_buf_w),
    .act_out      (cmp_b_act_w),
    .wave_out     (wave_b_w)
  );

  sequence s_reach_top;
    tick_w && dual_w && up_w && (cnt_q == top_w) && !wr_cnt_w;
  endsequence

  sequence s_turned_down(word_t t);
    (dir_q == DIR_DOWN) && (cnt_q == t - WORD_ONE);
  endsequence

  property p_top_turn;
    word_t t;
    (s_reach_top, t = top_w) |=> s_turned_down(t);
  endproperty

  a_top_turn: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in) p_top_turn)
    else $error("counter did not turn down after top");

  a_fixed_top: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in)
    (waveform_mode_select == MODE_PC9 && tick_w && up_w && !wr_cnt_w
     && cnt_q == TOP_9BIT) |=> (dir_q == DIR_DOWN))
    else $error("nine bit fixed top not honoured");

  a_bottom_turn: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in)
    (tick_w && dual_w && !up_w && cnt_q == BOTTOM && !wr_cnt_w)
    |=> (dir_q == DIR_UP) && (cnt_q == WORD_ONE))
    else $error("counter did not turn up at bottom");

  a_ovf_bottom: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in)
    (tick_w && dual_w && cnt_q == BOTTOM) |=> flags_q[FLAG_OVF])
    else $error("overflow flag not set at bottom");

  a_cmpa_flag: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in)
    (tick_w && cnt_q == cmp_a_act_w) |=> flags_q[FLAG_CMPA])
    else $error("compare A flag not set on match");

  a_capt_flag: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in)
    (tick_w && capt_top_w && cnt_q == cap_top_q)
    |=> flags_q[FLAG_CAPT])
    else $error("capture flag not set at top");

  a_pc_load: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in)
    (pc_w && tick_w && cnt_q == top_w && !wr_ctrl_w)
    |=> cmp_b_act_w == $past(cmp_b_buf_w))
    else $error("compare B not loaded at top");

  a_hold_still: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in)
    (!tick_w && !wr_cnt_w) |=> $stable(cnt_q))
    else $error("counter moved without a tick");

  a_pin_gate: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in)
    !pin_dir_q[0] |-> pin_a_oe_n_out && !pin_a_out)
    else $error("pin A driven with direction input");

endmodule
`default_nettype wire

// File: pin_load.sv
`timescale 1ns/100ps
`default_nettype none
module pin_load (
  input  wire logic pin_a_in,
  input  wire logic pin_a_oe_n_in,
  input  wire logic pin_b_in,
  input  wire logic pin_b_oe_n_in,
  output logic      pad_a_out,
  output logic      pad_b_out
);
  // A released pin is pulled low by the load.
  assign pad_a_out = pin_a_oe_n_in ? 1'b0 : pin_a_in;
  assign pad_b_out = pin_b_oe_n_in ? 1'b0 : pin_b_in;
endmodule
`default_nettype wire

// File: testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import pwm16_pkg::*;
  logic  clk_sys_in, nrst_in, wr_in, rd_in;
  addr_t addr_in;
  word_t wdata_in, rdata_out;
  logic  pin_a_out, pin_a_oe_n_out, pin_b_out, pin_b_oe_n_out;
  logic  pad_a, pad_b;
  int    err_count, num_checks;
  word_t cs [0:2199];
  logic  pas [0:2199];
  logic  pbs [0:2199];

  dual_slope_pwm_timer16 i_dual_slope_pwm_timer16 (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .pin_a_out(pin_a_out),
    .pin_a_oe_n_out(pin_a_oe_n_out), .pin_b_out(pin_b_out),
    .pin_b_oe_n_out(pin_b_oe_n_out));
  pin_load i_pin_load (
    .pin_a_in(pin_a_out), .pin_a_oe_n_in(pin_a_oe_n_out),
    .pin_b_in(pin_b_out), .pin_b_oe_n_in(pin_b_oe_n_out),
    .pad_a_out(pad_a), .pad_b_out(pad_b));

  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  task automatic check(input string nm, input word_t seen, input word_t exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task end_of_test;
    $display("Checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic wr(input addr_t a, input word_t d);
    @(posedge clk_sys_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input addr_t a, output word_t d);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask

  // Reads the count on every cycle and samples both pads alongside.
  task automatic burst(input int n);
    @(posedge clk_sys_in);
    addr_in <= ADDR_COUNT;
    rd_in   <= 1'b1;
    for (int j = 0; j < n; j++) begin
      @(posedge clk_sys_in);
      if (j == n - 1) rd_in <= 1'b0;
      #1;
      cs[j]  = rdata_out;
      pas[j] = pad_a;
      pbs[j] = pad_b;
    end
  endtask

  task automatic start(input logic [3:0] m, input logic [2:0] sel,
                       input word_t top, input word_t ca, input word_t cb,
                       input logic [1:0] coa, input logic [1:0] cob);
    wr(ADDR_CTRL, 16'h0000);
    wr(ADDR_COUNT, BOTTOM);
    wr(ADDR_CMP_A, ca);
    wr(ADDR_CMP_B, cb);
    wr(ADDR_CAP_TOP, top);
    wr(ADDR_FLAGS, 16'h000F);
    wr(ADDR_CTRL, {5'h00, sel, cob, coa, m});
  endtask

  task automatic reset_case;
    word_t d;
    #1;
    check("oe a reset", word_t'(pin_a_oe_n_out), 16'h0001);
    check("pad b reset", word_t'(pad_b), BOTTOM);
    wr(4'h8, 16'h1234);
    wr(ADDR_STATUS, 16'h0006);
    for (int i = 0; i < 9; i++) begin
      rd(addr_t'(i), d);
      check("register", d, (i == 7) ? 16'h0001 : BOTTOM);
    end
    @(posedge clk_sys_in);
    #1 check("rdata idle", rdata_out, BOTTOM);
  endtask

  task automatic run_tri(input logic [3:0] m, input word_t top);
    int    n, a, b, c;
    logic  bad;
    word_t mx, d, ef;
    bad = 1'b0;
    mx = BOTTOM;
    n = 2 * int'(top) + 6;
    ef = (m == MODE_PFC_IC || m == MODE_PC_IC) ? 16'h000B : 16'h0003;
    start(m, CSEL_DIV1, top, top, TOP_MAX, COM_OFF, COM_OFF);
    if (m inside {MODE_PC8, MODE_PC9, MODE_PC10}) begin
      wr(ADDR_CMP_A, TOP_MAX);
      rd(ADDR_CMP_A, d);
      check("masked compare", d, top);
    end
    burst(n);
    for (int j = 2; j < n; j++) begin
      a = cs[j-2];
      b = cs[j-1];
      c = cs[j];
      if (cs[j] > mx) mx = cs[j];
      if (b == top) bad |= (c != b - 1);
      else if (b == 0) bad |= (c != 1);
      else bad |= (c - b != b - a) || (c - b != 1 && b - c != 1);
    end
    check("peak", mx, top);
    check("slope", word_t'(bad), BOTTOM);
    rd(ADDR_FLAGS, d);
    check("flags", d, ef);
  endtask

  task automatic wave_case(input logic [3:0] m, input word_t cmp,
                           input logic [1:0] coa, input logic [1:0] dir);
    word_t      top, c;
    logic       w, up, seen, ea;
    logic [1:0] cob;
    top = 16'h0008;
    cob = (coa == COM_TOGGLE) ? COM_OFF : coa ^ 2'h1;
    seen = 1'b0;
    w = 1'b0;
    wr(ADDR_PIN_DIR, {14'h0000, dir});
    start(m, CSEL_DIV1, top, cmp, cmp, coa, cob);
    burst(60);
    for (int j = 1; j < 60; j++) begin
      c = cs[j];
      up = (c > cs[j-1]) || (c == BOTTOM);
      if (c == cmp) begin
        if (coa == COM_TOGGLE) w = seen ? ~w : ~pas[j-1];
        else if (cmp == BOTTOM) w = 1'b0;
        else if (cmp == top) w = 1'b1;
        else w = ~up;
        seen = 1'b1;
      end
      ea = (coa == COM_INV) ? ~w : w;
      if (seen) begin
        check("pin a", word_t'(pas[j]), word_t'(ea & dir[0]));
        check("pin b", word_t'(pbs[j]),
              word_t'(~ea & dir[1] & (cob != COM_OFF)));
      end
    end
    check("oe a", word_t'(pin_a_oe_n_out), word_t'(!dir[0]));
  endtask

  task automatic wait_rise(output int k);
    logic p;
    k = 0;
    p = pad_a;
    forever begin
      @(posedge clk_sys_in);
      #1;
      k++;
      if ((pad_a === 1'b1 && p === 1'b0) || k > 20000) break;
      p = pad_a;
    end
  endtask

  task automatic freq_case(input logic [2:0] sel, input int n);
    int k;
    wr(ADDR_PIN_DIR, 16'h0003);
    start(MODE_PC_IC, sel, 16'h0004, 16'h0002, 16'h0002, COM_NONINV,
          COM_NONINV);
    // The first rise may come only from the driver being enabled, so the
    // period is timed between the second and the third rise.
    wait_rise(k);
    wait_rise(k);
    wait_rise(k);
    check("period", word_t'(k), word_t'(8 * n));
  endtask

  task automatic buf_case(input logic [3:0] m, input addr_t a,
                          input word_t pk_exp);
    word_t pk, mx;
    pk = BOTTOM;
    mx = BOTTOM;
    start(m, CSEL_DIV1, 16'h0006, 16'h0006, BOTTOM, COM_OFF, COM_OFF);
    repeat (2) @(posedge clk_sys_in);
    wr(a, 16'h000A);
    burst(40);
    for (int j = 1; j < 40; j++) begin
      if (cs[j] < cs[j-1] && pk == BOTTOM) pk = cs[j-1];
      if (cs[j] > mx) mx = cs[j];
    end
    check("first peak", pk, pk_exp);
    check("later peak", mx, 16'h000A);
  endtask

  initial begin
    nrst_in = 1'b0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = ADDR_CTRL;
    wdata_in = BOTTOM;
    err_count = 0;
    num_checks = 0;
    repeat (10) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    reset_case;
    run_tri(MODE_PC8, TOP_8BIT);
    run_tri(MODE_PC9, TOP_9BIT);
    run_tri(MODE_PC10, TOP_10BIT);
    run_tri(MODE_PC_IC, 16'h0013);
    run_tri(MODE_PC_CA, 16'h0009);
    run_tri(MODE_PFC_IC, 16'h0007);
    run_tri(MODE_PFC_CA, 16'h0003);
    wave_case(MODE_PC_IC, 16'h0003, COM_NONINV, 2'b01);
    wave_case(MODE_PC_IC, 16'h0003, COM_INV, 2'b11);
    wave_case(MODE_PC_IC, BOTTOM, COM_NONINV, 2'b11);
    wave_case(MODE_PC_IC, BOTTOM, COM_INV, 2'b10);
    wave_case(MODE_PC_IC, 16'h0008, COM_NONINV, 2'b11);
    wave_case(MODE_PFC_IC, 16'h0008, COM_INV, 2'b11);
    wave_case(MODE_PFC_IC, 16'h0005, COM_NONINV, 2'b11);
    wave_case(MODE_PC_CA, 16'h0008, COM_TOGGLE, 2'b11);
    wave_case(MODE_PFC_CA, 16'h0008, COM_TOGGLE, 2'b11);
    buf_case(MODE_PFC_CA, ADDR_CMP_A, 16'h0006);
    buf_case(MODE_PFC_IC, ADDR_CAP_TOP, 16'h000A);
    buf_case(MODE_PC_CA, ADDR_CMP_A, 16'h0006);
    freq_case(CSEL_DIV1, 1);
    freq_case(CSEL_DIV8, 8);
    freq_case(CSEL_DIV64, 64);
    freq_case(CSEL_DIV256, 256);
    freq_case(CSEL_DIV1024, 1024);
    end_of_test;
  end

  initial begin
    #640000;
    err_count++;
    end_of_test;
  end
endmodule
`default_nettype wire
